// >>> hw/eesr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module eesr_regs #(
  parameter bit          STATUS_REG_PARAM     = 1'b1,
  parameter bit          SWITCH_REG_PARAM     = 1'b1,
  parameter bit          SWITCH_RESET_PARAM   = 1'b1,
  parameter int unsigned COUNT_WIDTH_PARAM    = 10,
  parameter bit          CORR_CAPTURE_PARAM   = 1'b1,
  parameter bit          UNCORR_CAPTURE_PARAM = 1'b1,
  parameter bit          FAULT_INJECT_PARAM   = 1'b1
) (
  input  wire  logic                 I_SYS_CLK,
  input  wire  logic                 I_RESETN,
  // control slave, axi4-lite
  input  wire  logic [9:0]           I_AXI_AWADDR,
  input  wire  logic                 I_AXI_AWVALID,
  output var   logic                 O_AXI_AWREADY,
  input  wire  logic [31:0]          I_AXI_WDATA,
  input  wire  logic [3:0]           I_AXI_WSTRB,
  input  wire  logic                 I_AXI_WVALID,
  output var   logic                 O_AXI_WREADY,
  output var   logic [1:0]           O_AXI_BRESP,
  output var   logic                 O_AXI_BVALID,
  input  wire  logic                 I_AXI_BREADY,
  input  wire  logic [9:0]           I_AXI_ARADDR,
  input  wire  logic                 I_AXI_ARVALID,
  output var   logic                 O_AXI_ARREADY,
  output var   logic [31:0]          O_AXI_RDATA,
  output var   logic [1:0]           O_AXI_RRESP,
  output var   logic                 O_AXI_RVALID,
  input  wire  logic                 I_AXI_RREADY,
  // error reports from the check logic
  input  wire  eesr_pkg::eesr_err_t  I_ERR,
  // memory write before and after fault injection
  input  wire  eesr_pkg::eesr_wr_t   I_MEM_WR,
  output var   eesr_pkg::eesr_wr_t   O_MEM_WR,
  // side outputs
  output var   logic                 O_CHECK_ENABLE,
  output var   logic                 O_IRQ,
  output var   logic                 O_CORR_ERR_PULSE,
  output var   logic                 O_UNCORR_ERR_PULSE
);
  import eesr_pkg::*;

  // counter present only for a nonzero width
  localparam bit COUNT_PRESENT = (COUNT_WIDTH_PARAM != 0);

  // saturation value for a given counter width
  function automatic logic [31:0] sat_max(input int unsigned w);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++)
    begin
      m[i] = (i < w);
    end
    return m;
  endfunction

  // expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // merge a strobed write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] m;
    m = strb_mask(strb);
    return (old_v & ~m) | (new_v & m);
  endfunction

  // read address compare, kept short for the decode chain;
  // declared ahead of the decode process that calls it
  function automatic logic I_ARADDR_IS(input logic [9:0] off);
    return I_AXI_ARADDR == off;
  endfunction

  localparam logic [31:0] CNT_MAX = sat_max(COUNT_WIDTH_PARAM);

  eesr_state_t s;          // registered state
  eesr_state_t n;          // next state

  // decoded bus and event terms
  logic        wr_go;      // write handshake this cycle
  logic        rd_go;      // read handshake this cycle
  logic [31:0] wmask;      // strobed write data
  logic        check_eff;  // checking actually on
  logic        ce_ev;      // qualified correctable error
  logic        ue_ev;      // qualified uncorrectable error
  logic        clr_ce;     // software clear of correctable flag
  logic        clr_ue;     // software clear of uncorrectable flag
  logic        cnt_wr;     // software load of counter
  logic        fi_d_wr;    // software load of data fault mask
  logic        fi_c_wr;    // software load of check fault mask

  // handshakes complete when our ready meets a held valid
  assign wr_go = s.awready && I_AXI_AWVALID && I_AXI_WVALID;
  assign rd_go = s.arready && I_AXI_ARVALID;
  assign wmask = I_AXI_WDATA & strb_mask(I_AXI_WSTRB);

  // without a switch register checking is always on
  assign check_eff = SWITCH_REG_PARAM ? s.check_on : 1'b1;
  assign ce_ev = I_ERR.corr && check_eff;
  assign ue_ev = I_ERR.uncorr && check_eff;

  // write-side decode, absent groups never match
  assign clr_ce = wr_go && STATUS_REG_PARAM
                  && (I_AXI_AWADDR == OFF_STATUS) && wmask[POS_CE];
  assign clr_ue = wr_go && STATUS_REG_PARAM
                  && (I_AXI_AWADDR == OFF_STATUS) && wmask[POS_UE];
  assign cnt_wr = wr_go && COUNT_PRESENT
                  && (I_AXI_AWADDR == OFF_COUNT);
  assign fi_d_wr = wr_go && FAULT_INJECT_PARAM
                   && (I_AXI_AWADDR == OFF_FI_DATA);
  assign fi_c_wr = wr_go && FAULT_INJECT_PARAM
                   && (I_AXI_AWADDR == OFF_FI_CHECK);

  // next-state logic for bus, flags, counter, captures and injection
  always_comb
  begin
    logic ce_arm;
    logic ue_arm;
    logic wr_hit;
    ce_arm = 1'b0;
    ue_arm = 1'b0;
    wr_hit = 1'b0;
    n = s;

    // write channel: ready for one cycle once both valids stand
    n.awready = I_AXI_AWVALID && I_AXI_WVALID && !s.awready && !s.bvalid;
    if (s.bvalid && I_AXI_BREADY)
    begin
      n.bvalid = 1'b0;
    end
    // read channel: same single-cycle ready scheme
    n.arready = I_AXI_ARVALID && !s.arready && !s.rvalid;
    if (s.rvalid && I_AXI_RREADY)
    begin
      n.rvalid = 1'b0;
    end

    // a capture slot is open while its flag is low or being cleared;
    // the clear re-arms in the same cycle so a coincident error is kept
    ce_arm = !s.ce_flag || clr_ce;
    ue_arm = !s.ue_flag || clr_ue;

    // sticky flags, set wins over clear, enables not consulted
    n.ce_flag = (s.ce_flag && !clr_ce) || ce_ev;
    n.ue_flag = (s.ue_flag && !clr_ue) || ue_ev;

    // first-failure captures, same cycle as the flag set
    if (CORR_CAPTURE_PARAM && ce_ev && ce_arm)
    begin
      n.ce_data  = I_ERR.data;
      n.ce_check = I_ERR.check;
      n.ce_addr  = I_ERR.addr;
    end
    if (UNCORR_CAPTURE_PARAM && ue_ev && ue_arm)
    begin
      n.ue_data  = I_ERR.data;
      n.ue_check = I_ERR.check;
      n.ue_addr  = I_ERR.addr;
    end

    // saturating count of correctable errors
    if (COUNT_PRESENT && ce_ev && (s.count != CNT_MAX))
    begin
      n.count = (s.count + 32'h0000_0001) & CNT_MAX;
    end

    // fault injection: toggle the outgoing word, then drop the masks
    n.wr.valid = I_MEM_WR.valid;
    n.wr.data  = I_MEM_WR.data;
    n.wr.check = I_MEM_WR.check;
    if (I_MEM_WR.valid && FAULT_INJECT_PARAM)
    begin
      n.wr.data  = I_MEM_WR.data ^ s.fi_data;
      n.wr.check = I_MEM_WR.check ^ s.fi_check;
      n.fi_data  = RST_WORD;
      n.fi_check = RST_CHECK;
    end

    // register writes; a load beats a same-cycle increment or clear
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      wr_hit   = 1'b1;
      if (STATUS_REG_PARAM && I_AXI_AWADDR == OFF_STATUS)
      begin
        // handled by the clear terms above
        wr_hit = 1'b1;
      end
      else if (STATUS_REG_PARAM && I_AXI_AWADDR == OFF_IRQ_EN)
      begin
        if (I_AXI_WSTRB[0])
        begin
          n.ce_irq_en = I_AXI_WDATA[POS_CE];
          n.ue_irq_en = I_AXI_WDATA[POS_UE];
        end
      end
      else if (SWITCH_REG_PARAM && I_AXI_AWADDR == OFF_SWITCH)
      begin
        if (I_AXI_WSTRB[0])
        begin
          n.check_on = I_AXI_WDATA[POS_SWITCH];
        end
      end
      else if (cnt_wr)
      begin
        n.count = wmerge(s.count, I_AXI_WDATA, I_AXI_WSTRB)
                  & CNT_MAX;
      end
      else if (fi_d_wr)
      begin
        n.fi_data = wmerge(s.fi_data, I_AXI_WDATA, I_AXI_WSTRB);
      end
      else if (fi_c_wr)
      begin
        n.fi_check = wmask[CHECK_W-1:0];
      end
      else if (CORR_CAPTURE_PARAM && (I_AXI_AWADDR == OFF_CE_DATA
               || I_AXI_AWADDR == OFF_CE_CHECK
               || I_AXI_AWADDR == OFF_CE_ADDR))
      begin
        // read-only captures ignore writes
        wr_hit = 1'b1;
      end
      else if (UNCORR_CAPTURE_PARAM && (I_AXI_AWADDR == OFF_UE_DATA
               || I_AXI_AWADDR == OFF_UE_CHECK
               || I_AXI_AWADDR == OFF_UE_ADDR))
      begin
        wr_hit = 1'b1;
      end
      else
      begin
        wr_hit = 1'b0;
      end
      if (!wr_hit)
      begin
        n.bresp = RESP_DECERR;
      end
    end

    // register reads; absent groups answer decode error
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = RST_WORD;
      if (STATUS_REG_PARAM && I_ARADDR_IS(OFF_STATUS))
      begin
        n.rdata[POS_CE] = s.ce_flag;
        n.rdata[POS_UE] = s.ue_flag;
      end
      else if (STATUS_REG_PARAM && I_ARADDR_IS(OFF_IRQ_EN))
      begin
        n.rdata[POS_CE] = s.ce_irq_en;
        n.rdata[POS_UE] = s.ue_irq_en;
      end
      else if (SWITCH_REG_PARAM && I_ARADDR_IS(OFF_SWITCH))
      begin
        n.rdata[POS_SWITCH] = s.check_on;
      end
      else if (COUNT_PRESENT && I_ARADDR_IS(OFF_COUNT))
      begin
        n.rdata = s.count;
      end
      else if (CORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_CE_DATA))
      begin
        n.rdata = s.ce_data;
      end
      else if (CORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_CE_CHECK))
      begin
        n.rdata[CHECK_W-1:0] = s.ce_check;
      end
      else if (CORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_CE_ADDR))
      begin
        n.rdata = s.ce_addr;
      end
      else if (UNCORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_UE_DATA))
      begin
        n.rdata = s.ue_data;
      end
      else if (UNCORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_UE_CHECK))
      begin
        n.rdata[CHECK_W-1:0] = s.ue_check;
      end
      else if (UNCORR_CAPTURE_PARAM && I_ARADDR_IS(OFF_UE_ADDR))
      begin
        n.rdata = s.ue_addr;
      end
      else if (FAULT_INJECT_PARAM && (I_ARADDR_IS(OFF_FI_DATA)
               || I_ARADDR_IS(OFF_FI_CHECK)))
      begin
        // write-only masks read back as zero
        n.rdata = RST_WORD;
      end
      else
      begin
        n.rresp = RESP_DECERR;
      end
    end

    // interrupt level follows the next flags and enables
    n.irq = STATUS_REG_PARAM && ((n.ce_flag && n.ce_irq_en)
            || (n.ue_flag && n.ue_irq_en));
    // error pulses, one cycle per reported access
    n.ce_pulse = ce_ev;
    n.ue_pulse = ue_ev;
  end

  // state register, everything resets to constants
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      s          <= '0;
      s.check_on <= SWITCH_RESET_PARAM;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from state flops
  assign O_AXI_AWREADY      = s.awready;
  assign O_AXI_WREADY       = s.awready;
  assign O_AXI_BRESP        = s.bresp;
  assign O_AXI_BVALID       = s.bvalid;
  assign O_AXI_ARREADY      = s.arready;
  assign O_AXI_RDATA        = s.rdata;
  assign O_AXI_RRESP        = s.rresp;
  assign O_AXI_RVALID       = s.rvalid;
  assign O_MEM_WR           = s.wr;
  assign O_CHECK_ENABLE     = s.check_on;
  assign O_IRQ              = s.irq;
  assign O_CORR_ERR_PULSE   = s.ce_pulse;
  assign O_UNCORR_ERR_PULSE = s.ue_pulse;

  // checks on the guarded behaviour
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  // first correctable error while the correctable flag is low
  sequence ce_first_s;
    CORR_CAPTURE_PARAM && ce_ev && !s.ce_flag;
  endsequence

  sequence fi_apply_s;
    I_MEM_WR.valid && FAULT_INJECT_PARAM && !fi_d_wr;
  endsequence

  flag_set_a: assert property (ce_ev |=> s.ce_flag)
    else $error("correctable flag not set");
  w1c_clear_a: assert property (clr_ue && !ue_ev |=> !s.ue_flag)
    else $error("uncorrectable flag not cleared");
  no_write_set_a: assert property ($rose(s.ce_flag) |-> $past(ce_ev))
    else $error("correctable flag rose without an error");
  irq_level_a: assert property (##1 s.irq == (STATUS_REG_PARAM &&
      ((s.ce_flag && s.ce_irq_en) || (s.ue_flag && s.ue_irq_en))))
    else $error("interrupt does not follow flags");
  count_sat_a: assert property (COUNT_PRESENT && ce_ev && !cnt_wr &&
      s.count == CNT_MAX |=> s.count == CNT_MAX)
    else $error("counter left saturation");
  count_inc_a: assert property (COUNT_PRESENT && ce_ev && !cnt_wr &&
      s.count != CNT_MAX |=> s.count == $past(s.count) + 32'h0000_0001)
    else $error("counter did not increment");
  capture_same_a: assert property (ce_first_s
      |=> s.ce_flag && s.ce_addr == $past(I_ERR.addr))
    else $error("capture and flag not in the same cycle");
  capture_hold_a: assert property (s.ce_flag && !clr_ce
      |=> $stable(s.ce_addr) && $stable(s.ce_data))
    else $error("correctable capture changed while held");
  fi_clear_a: assert property (fi_apply_s |=> s.fi_data == RST_WORD
      && s.wr.data == ($past(I_MEM_WR.data) ^ $past(s.fi_data)))
    else $error("data fault mask not applied once");
  check_off_a: assert property (!check_eff && I_ERR.corr && !cnt_wr
      |=> !O_CORR_ERR_PULSE && $stable(s.count))
    else $error("error recorded while checking off");
  pulse_once_a: assert property (ue_ev ##1 !ue_ev
      |=> !O_UNCORR_ERR_PULSE)
    else $error("uncorrectable pulse longer than one cycle");

endmodule
`default_nettype wire

// >>> shared/eesr_pkg.sv
`default_nettype none
// shared constants and carriers for the error status register bank
package eesr_pkg;

  // register byte offsets on the control slave
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] OFF_STATUS    = 10'h000;
  localparam logic [9:0] OFF_IRQ_EN    = 10'h004;
  localparam logic [9:0] OFF_SWITCH    = 10'h008;
  localparam logic [9:0] OFF_COUNT     = 10'h00C;
  localparam logic [9:0] OFF_CE_DATA   = 10'h100;
  localparam logic [9:0] OFF_CE_CHECK  = 10'h180;
  localparam logic [9:0] OFF_CE_ADDR   = 10'h1C0;
  localparam logic [9:0] OFF_UE_DATA   = 10'h200;
  localparam logic [9:0] OFF_UE_CHECK  = 10'h280;
  localparam logic [9:0] OFF_UE_ADDR   = 10'h2C0;
  localparam logic [9:0] OFF_FI_DATA   = 10'h300;
  localparam logic [9:0] OFF_FI_CHECK  = 10'h380;

  // field positions, lsb-0 numbering (bit 31 msb-0 is bit 0 here)
  localparam int unsigned POS_CE     = 1;
  localparam int unsigned POS_UE     = 0;
  localparam int unsigned POS_SWITCH = 0;
  localparam int unsigned CHECK_W    = 7;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [6:0]  RST_CHECK = 7'h00;

  // one access reported by the check logic
  typedef struct packed {
    logic        corr;
    logic        uncorr;
    logic [31:0] data;
    logic [6:0]  check;
    logic [31:0] addr;
  } eesr_err_t;

  // one memory write, data with its check bits
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [6:0]  check;
  } eesr_wr_t;

  // all state of the register bank
  typedef struct packed {
    logic        awready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic        ce_flag;
    logic        ue_flag;
    logic        ce_irq_en;
    logic        ue_irq_en;
    logic        check_on;
    logic [31:0] count;
    logic [31:0] ce_data;
    logic [6:0]  ce_check;
    logic [31:0] ce_addr;
    logic [31:0] ue_data;
    logic [6:0]  ue_check;
    logic [31:0] ue_addr;
    logic [31:0] fi_data;
    logic [6:0]  fi_check;
    logic        irq;
    logic        ce_pulse;
    logic        ue_pulse;
    eesr_wr_t    wr;
  } eesr_state_t;

endpackage
`default_nettype wire

// >>> test/eesr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the processor core on the local memory bus
module eesr_core_model (
  input  wire logic               i_clk,
  input  wire eesr_pkg::eesr_wr_t i_mem_wr,
  output var  eesr_pkg::eesr_err_t o_err,
  output var  eesr_pkg::eesr_wr_t  o_mem_wr
);
  import eesr_pkg::*;

  initial
  begin
    o_err    = '0;
    o_mem_wr = '0;
  end

  // one failing access, fields scrambled afterwards so nothing stale
  // is mistaken for a capture
  task automatic report(input logic c, input logic u, input logic [31:0] d,
                        input logic [6:0] k, input logic [31:0] a);
    @(posedge i_clk);
    o_err <= '{corr: c, uncorr: u, data: d, check: k, addr: a};
    @(posedge i_clk);
    o_err <= '{corr: 1'b0, uncorr: 1'b0, data: ~d, check: ~k, addr: ~a};
  endtask

  // one memory write; the word seen after injection is handed back
  task automatic mem_write(input logic [31:0] d, input logic [6:0] k,
                           output eesr_wr_t seen);
    @(posedge i_clk);
    o_mem_wr <= '{valid: 1'b1, data: d, check: k};
    @(posedge i_clk);
    o_mem_wr <= '{valid: 1'b0, data: ~d, check: ~k};
    @(negedge i_clk);
    seen = i_mem_wr;
  endtask
endmodule
`default_nettype wire

// >>> test/ecc_error_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ecc_error_status_regs_bench;
  import eesr_pkg::*;
  localparam int CW = 10;                  // counter width under test
  localparam logic [31:0] CMAX = 32'h0000_03FF;
  logic        clk, rst_n;
  logic [9:0]  aw_addr, ar_addr;
  logic        aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic [31:0] w_data, r_data;
  logic [3:0]  w_strb;
  logic        aw_rdy, w_rdy, b_valid, ar_rdy, r_valid;
  logic [1:0]  b_resp, r_resp, last_resp;
  eesr_err_t   err;
  eesr_wr_t    mw_in, mw_out, seen;
  logic        chk_en, irq, cep, uep;
  int          errors, tests_run, cycles, seed, np_ce, np_ue, sp_ce, sp_ue;
  // expected state kept by the bench
  logic        ce, ue, en_ce, en_ue, on;
  logic [31:0] cnt, ce_d, ce_a, ue_d, ue_a, r, m;
  logic [6:0]  ce_c, ue_c, k;

  eesr_regs #(.SWITCH_RESET_PARAM(1'b0), .COUNT_WIDTH_PARAM(CW)) dut (
    .I_SYS_CLK(clk), .I_RESETN(rst_n),
    .I_AXI_AWADDR(aw_addr), .I_AXI_AWVALID(aw_valid),
    .O_AXI_AWREADY(aw_rdy), .I_AXI_WDATA(w_data), .I_AXI_WSTRB(w_strb),
    .I_AXI_WVALID(w_valid), .O_AXI_WREADY(w_rdy), .O_AXI_BRESP(b_resp),
    .O_AXI_BVALID(b_valid), .I_AXI_BREADY(b_ready),
    .I_AXI_ARADDR(ar_addr), .I_AXI_ARVALID(ar_valid),
    .O_AXI_ARREADY(ar_rdy), .O_AXI_RDATA(r_data), .O_AXI_RRESP(r_resp),
    .O_AXI_RVALID(r_valid), .I_AXI_RREADY(r_ready),
    .I_ERR(err), .I_MEM_WR(mw_out), .O_MEM_WR(mw_in),
    .O_CHECK_ENABLE(chk_en), .O_IRQ(irq),
    .O_CORR_ERR_PULSE(cep), .O_UNCORR_ERR_PULSE(uep));

  eesr_core_model core (.i_clk(clk), .i_mem_wr(mw_in), .o_err(err),
                        .o_mem_wr(mw_out));

  always #25 clk = ~clk;

  // pulse counter doubles as a width check: a long pulse over-counts
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    sp_ce  <= sp_ce + int'(cep === 1'b1);
    sp_ue  <= sp_ue + int'(uep === 1'b1);
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait, sampled mid-cycle where registered outputs are settled
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge clk);
    while (s !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1;
    b_ready <= 1'b1;
    wait_hi(aw_rdy);
    @(posedge clk);
    aw_valid <= 1'b0; w_valid <= 1'b0;
    wait_hi(b_valid);
    last_resp = b_resp;
    @(posedge clk);
    b_ready <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
    wait_hi(ar_rdy);
    @(posedge clk);
    ar_valid <= 1'b0;
    wait_hi(r_valid);
    last_resp = r_resp;
    check(r_data, exp);
    @(posedge clk);
    r_ready <= 1'b0;
  endtask

  function automatic logic [31:0] st();
    st = (32'(ce) << POS_CE) | (32'(ue) << POS_UE);
  endfunction

  // one failing access plus what the bank should make of it
  task automatic ev(input logic c, input logic u);
    logic [31:0] d, a;
    d = $random(seed); a = $random(seed); k = 7'($random(seed));
    core.report(c, u, d, k, a);
    if (on)
    begin
      if (c && !ce) begin ce_d = d; ce_c = k; ce_a = a; end
      if (u && !ue) begin ue_d = d; ue_c = k; ue_a = a; end
      ce |= c;
      ue |= u;
      if (c && cnt != CMAX) cnt++;
      np_ce += int'(c);
      np_ue += int'(u);
    end
  endtask

  task automatic verify();
    rchk(OFF_STATUS, st());
    rchk(OFF_COUNT, cnt);
    rchk(OFF_CE_DATA, ce_d);
    rchk(OFF_CE_CHECK, {25'h0, ce_c});
    rchk(OFF_CE_ADDR, ce_a);
    rchk(OFF_UE_DATA, ue_d);
    rchk(OFF_UE_CHECK, {25'h0, ue_c});
    rchk(OFF_UE_ADDR, ue_a);
    check({31'h0, irq}, {31'h0, (ce & en_ce) | (ue & en_ue)});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 0; rst_n = 0; seed = 32'hc6b5;
    aw_addr = '0; ar_addr = '0; aw_valid = 0; w_valid = 0; b_ready = 0;
    ar_valid = 0; r_ready = 0; w_data = '0; w_strb = 4'hF;
    {ce, ue, en_ce, en_ue, on} = '0;
    {cnt, ce_d, ce_a, ue_d, ue_a, ce_c, ue_c} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // every register starts at zero, captures armed
    verify();
    rchk(OFF_IRQ_EN, 32'h0);
    rchk(OFF_SWITCH, 32'h0);
    check({31'h0, chk_en}, 32'h0);
    rchk(10'h010, 32'h0);
    check({30'h0, last_resp}, {30'h0, RESP_DECERR});
    // unmapped write is refused with a decode error
    wr(10'h010, 32'hFFFF_FFFF);
    check({30'h0, last_resp}, {30'h0, RESP_DECERR});
    // checking off: errors leave no trace
    ev(1'b1, 1'b1);
    verify();
    // memory initialised by four writes of random data before switching on
    repeat (4) core.mem_write($random(seed), 7'h00, seen);
    wr(OFF_SWITCH, 32'h1);
    on = 1'b1;
    rchk(OFF_SWITCH, 32'h1);
    check({31'h0, chk_en}, 32'h1);
    // enables off yet flags record; second error keeps first capture
    ev(1'b1, 1'b0);
    ev(1'b1, 1'b0);
    verify();
    wr(OFF_IRQ_EN, 32'h1 << POS_CE);
    en_ce = 1'b1;
    rchk(OFF_IRQ_EN, 32'h1 << POS_CE);
    wr(OFF_STATUS, 32'h0);
    wr(OFF_STATUS, 32'h1 << POS_UE);
    verify();
    ev(1'b0, 1'b1);
    wr(OFF_IRQ_EN, 32'h3);
    en_ue = 1'b1;
    wr(OFF_STATUS, 32'h1 << POS_CE);
    ce = 1'b0;
    verify();
    ev(1'b1, 1'b0);
    wr(OFF_CE_ADDR, $random(seed));
    check({30'h0, last_resp}, {30'h0, RESP_OKAY});
    verify();
    // random mix of errors, flag clears and counter loads
    repeat (20)
    begin
      r = $random(seed);
      case (r[1:0])
        2'd0: wr(OFF_STATUS, {30'h0, r[3:2]});
        2'd1: wr(OFF_COUNT, r);
        default: ev(r[4], r[5]);
      endcase
      // status bit 1 clears correctable, bit 0 uncorrectable
      if (r[1:0] == 2'd0) begin ce &= ~r[3]; ue &= ~r[2]; end
      if (r[1:0] == 2'd1) cnt = r & CMAX;
      verify();
    end
    // counter load is masked to width and saturates at all ones
    wr(OFF_COUNT, 32'hFFFF_FFFE);
    cnt = CMAX - 1;
    ev(1'b1, 1'b0);
    ev(1'b1, 1'b0);
    verify();
    // fault masks loaded and used by the very next write
    m = $random(seed);
    k = 7'($random(seed));
    r = $random(seed);
    wr(OFF_FI_DATA, m);
    wr(OFF_FI_CHECK, {25'h0, k});
    core.mem_write(r, 7'h55, seen);
    check({31'h0, seen.valid}, 32'h1);
    check(seen.data, r ^ m);
    check({25'h0, seen.check}, {25'h0, 7'h55 ^ k});
    core.mem_write(r, 7'h55, seen);
    check(seen.data, r);
    check({25'h0, seen.check}, 32'h55);
    rchk(OFF_FI_DATA, 32'h0);
    check(sp_ce, np_ce);
    check(sp_ue, np_ue);
    results();
  end
endmodule
`default_nettype wire
